// [verilog/tip_ctrl.sv]
// Twelve-source two-level interrupt priority controller with APB registers.
// Assumes a core that flags its last machine cycle, blocking instructions,
// return-from-interrupt and plain return, and performs the pushing call.
//
// Contract
// RULE1 - two levels, per-source priority bit
// RULE2 - high service never preempted by low
// RULE3 - fixed order among equal levels
// RULE4 - sample and poll every machine cycle
// RULE5 - no call under equal or higher service
// RULE6 - call only in instruction's last cycle
// RULE7 - block call on enable/priority write, return
// RULE8 - denied requests are not remembered
// RULE9 - vectoring clears timer 0/1 flags
// RULE10 - ext0/1 flag cleared only if edge-triggered
// RULE11 - serial flags left for software
// RULE12 - timer 2 flags left for software
// RULE13 - watchdog flag cleared only by software
// RULE14 - call pushes program counter, no status word
// RULE15 - fixed vector address per source
// RULE16 - return-from-interrupt ends service at level
// RULE17 - plain return keeps service state
// RULE18 - external pins sampled at phase C3
// RULE19 - timer flags polled next machine cycle
// RULE20 - call lasts four machine cycles
// RULE21 - timer2 and serial requests are ORed flags
// RULE22 - per-source enables plus global enable
// RULE23 - ext2-5 edge only, optional hardware clear
// RULE24 - machine cycle is four clocks
// RULE25 - one in-service bit per level
// RULE26 - reset clears service and pending calls
`timescale 1ns/100ps
`default_nettype none
`include "tip_defines.svh"

module tip_ctrl
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  ext_interrupt_pin_n,
  input  wire logic        timer0_overflow,
  input  wire logic        timer1_overflow,
  input  wire logic        serial0_receive_flag,
  input  wire logic        serial0_transmit_flag,
  input  wire logic        timer2_overflow_flag,
  input  wire logic        timer2_external_flag,
  input  wire logic        serial1_receive_flag,
  input  wire logic        serial1_transmit_flag,
  input  wire logic        watchdog_interrupt_flag,
  input  wire logic        core_last_cycle,
  input  wire logic        core_block_call,
  input  wire logic        core_return_from_interrupt,
  input  wire logic        core_ret,
  output logic             hw_call,
  output logic [15:0]      call_vector,
  output logic             call_level
);
  import tip_pkg::*;

  tip_state_s st_q;
  tip_state_s st_d;
  tip_pkg::tip_src_t flags_all;
  tip_pkg::tip_src_t enabled;
  tip_pkg::tip_src_t prio;
  tip_pkg::tip_src_t cand;
  logic        setup;
  logic        access;
  logic        mapped;
  logic [3:0]  sel;
  logic        sel_hit;
  logic        sel_level;
  logic [15:0] sel_vec;
  logic [5:0]  pin_sample;
  logic [5:0]  pin_fall;

  // APB phases; zero wait states
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= `TIP_OFF_STAT);
  assign pslverr = access && !mapped;

  // RULE21 timer2/serial OR
  // RULE11 serial flags read only
  // RULE12 timer2 flags read only
  // RULE13 watchdog flag read only
  assign flags_all = {watchdog_interrupt_flag, st_q.ext_flag[5:2],
                      serial1_receive_flag | serial1_transmit_flag,
                      timer2_overflow_flag | timer2_external_flag,
                      serial0_receive_flag | serial0_transmit_flag,
                      st_q.t1_flag, st_q.ext_flag[1], st_q.t0_flag, st_q.ext_flag[0]};

  // RULE22 individual and global enables
  assign enabled = {st_q.een, st_q.en[6:0]} & {12{st_q.en[`TIP_EN_GLOBAL_BIT]}};
  // RULE1 per-source level bit
  assign prio = {st_q.epri, st_q.pri};

  // Falling edges seen between two C3 samples
  assign pin_sample = st_q.pin_lvl;
  assign pin_fall   = st_q.pin_prev & ~pin_sample;

  // Priority resolution on this machine cycle's poll
  always_comb
  begin
    cand      = '0;
    sel       = 4'h0;
    sel_hit   = 1'b0;
    sel_level = 1'b0;
    // RULE2 high-level request wins over low
    // RULE5 equal or higher service masks
    if (|(st_q.polled & prio) && !st_q.in_service[1])
    begin
      cand      = st_q.polled & prio;
      sel_level = 1'b1;
    end
    else if (st_q.in_service == 2'h0)
    begin
      cand = st_q.polled & ~prio;
    end
    // RULE3 lowest index is highest order
    for (int i = 11; i >= 0; i--)
    begin
      if (cand[i])
      begin
        sel     = 4'(i);
        sel_hit = 1'b1;
      end
    end
  end

  // RULE15 vector table
  always_comb
  begin
    case (sel)
      4'h0:    sel_vec = `TIP_VEC_EXT0;
      4'h1:    sel_vec = `TIP_VEC_TIMER0;
      4'h2:    sel_vec = `TIP_VEC_EXT1;
      4'h3:    sel_vec = `TIP_VEC_TIMER1;
      4'h4:    sel_vec = `TIP_VEC_SER0;
      4'h5:    sel_vec = `TIP_VEC_TIMER2;
      4'h6:    sel_vec = `TIP_VEC_SER1;
      4'h7:    sel_vec = `TIP_VEC_EXT2;
      4'h8:    sel_vec = `TIP_VEC_EXT3;
      4'h9:    sel_vec = `TIP_VEC_EXT4;
      4'hA:    sel_vec = `TIP_VEC_EXT5;
      default: sel_vec = `TIP_VEC_WDOG;
    endcase
  end

  // Next state of the whole block
  always_comb
  begin
    st_d      = st_q;
    st_d.call = 1'b0;
    // RULE24 four clocks per machine cycle
    st_d.phase = st_q.phase + 2'h1;
    // Three-stage pin synchroniser; level moves when stages two and three agree
    st_d.pin_s1 = ext_interrupt_pin_n;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.pin_s3 = st_q.pin_s2;
    for (int i = 0; i < 6; i++)
    begin
      if (st_q.pin_s2[i] == st_q.pin_s3[i])
      begin
        st_d.pin_lvl[i] = st_q.pin_s3[i];
      end
    end

    // Register writes; software clears first so hardware sets win
    if (access && pwrite)
    begin
      case (paddr)
        `TIP_OFF_EN:   st_d.en = pwdata[7:0];
        `TIP_OFF_EEN:  st_d.een = pwdata[4:0];
        `TIP_OFF_PRI:  st_d.pri = pwdata[6:0];
        `TIP_OFF_EPRI: st_d.epri = pwdata[4:0];
        `TIP_OFF_FLAG:
        begin
          st_d.ext_flag = st_q.ext_flag & ~{pwdata[10:7], pwdata[2], pwdata[0]};
          st_d.t0_flag  = st_q.t0_flag & !pwdata[`TIP_SRC_TIMER0];
          st_d.t1_flag  = st_q.t1_flag & !pwdata[`TIP_SRC_TIMER1];
        end
        `TIP_OFF_FSET:
        begin
          st_d.ext_flag = st_q.ext_flag | {pwdata[10:7], pwdata[2], pwdata[0]};
          st_d.t0_flag  = st_q.t0_flag | pwdata[`TIP_SRC_TIMER0];
          st_d.t1_flag  = st_q.t1_flag | pwdata[`TIP_SRC_TIMER1];
        end
        `TIP_OFF_CFG:
        begin
          st_d.edge_mode = pwdata[1:0];
          st_d.hw_clr    = pwdata[5:2];
        end
        default: ;
      endcase
    end

    // RULE8 fresh poll each machine cycle
    // RULE19 flags set at C3 poll next cycle
    if (st_q.phase == `TIP_PH_C1)
    begin
      st_d.polled = flags_all & enabled;
    end

    // RULE16 return-from-interrupt ends highest level
    // RULE17 plain return ignored here
    if (core_return_from_interrupt)
    begin
      if (st_q.in_service[1])
      begin
        st_d.in_service[1] = 1'b0;
      end
      else
      begin
        st_d.in_service[0] = 1'b0;
      end
    end

    // Decision at C4; busy counts down the call's own cycles
    if (st_q.phase == `TIP_PH_C4)
    begin
      if (st_q.busy != 3'h0)
      begin
        st_d.busy = st_q.busy - 3'h1;
      end
      // RULE4 polled and resolved each cycle
      // RULE6 only at instruction's last cycle
      // RULE7 blocked instructions defer call
      else if (sel_hit && core_last_cycle && !core_block_call && !core_return_from_interrupt)
      begin
        st_d.call       = 1'b1;
        st_d.call_level = sel_level;
        st_d.vector     = sel_vec;
        // RULE20 call occupies four machine cycles
        st_d.busy = `TIP_CALL_MCYCLES;
        // RULE25 service bit per level
        st_d.in_service[sel_level] = 1'b1;
        // RULE9 timer flags cleared on vectoring
        if (sel == 4'(`TIP_SRC_TIMER0))
        begin
          st_d.t0_flag = 1'b0;
        end
        if (sel == 4'(`TIP_SRC_TIMER1))
        begin
          st_d.t1_flag = 1'b0;
        end
        // RULE10 ext0/1 cleared only in edge mode
        if (sel == 4'h0 && st_q.edge_mode[0])
        begin
          st_d.ext_flag[0] = 1'b0;
        end
        if (sel == 4'h2 && st_q.edge_mode[1])
        begin
          st_d.ext_flag[1] = 1'b0;
        end
        // RULE23 ext2-5 hardware clear when enabled
        for (int i = 0; i < 4; i++)
        begin
          if (sel == 4'(i + 7) && st_q.hw_clr[i])
          begin
            st_d.ext_flag[i + 2] = 1'b0;
          end
        end
      end
    end

    // RULE18 pins sampled at C3 set or reset flags
    if (st_q.phase == `TIP_PH_C3)
    begin
      st_d.pin_prev = pin_sample;
      for (int i = 0; i < 2; i++)
      begin
        if (!st_q.edge_mode[i])
        begin
          st_d.ext_flag[i] = !pin_sample[i];
        end
        else if (pin_fall[i])
        begin
          st_d.ext_flag[i] = 1'b1;
        end
      end
      // RULE23 ext2-5 edge only
      st_d.ext_flag[5:2] = st_d.ext_flag[5:2] | pin_fall[5:2];
    end
    // Overflow events win over any clear in the same cycle
    if (timer0_overflow)
    begin
      st_d.t0_flag = 1'b1;
    end
    if (timer1_overflow)
    begin
      st_d.t1_flag = 1'b1;
    end

    // Read data captured in the setup cycle
    if (setup)
    begin
      case (paddr)
        `TIP_OFF_EN:   st_d.prdata = {24'h000000, st_q.en};
        `TIP_OFF_EEN:  st_d.prdata = {27'h0000000, st_q.een};
        `TIP_OFF_PRI:  st_d.prdata = {25'h0000000, st_q.pri};
        `TIP_OFF_EPRI: st_d.prdata = {27'h0000000, st_q.epri};
        `TIP_OFF_FLAG: st_d.prdata = {20'h00000, flags_all};
        `TIP_OFF_CFG:  st_d.prdata = {26'h0000000, st_q.hw_clr, st_q.edge_mode};
        `TIP_OFF_STAT: st_d.prdata = {st_q.vector, st_q.polled, st_q.busy != 3'h0, 1'b0, st_q.in_service};
        default:       st_d.prdata = 32'h00000000;
      endcase
    end
  end

  // State register; RULE26 reset clears service and pending calls
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q           <= '0;
      st_q.pin_s1    <= 6'h3F;
      st_q.pin_s2    <= 6'h3F;
      st_q.pin_s3    <= 6'h3F;
      st_q.pin_lvl   <= 6'h3F;
      st_q.pin_prev  <= 6'h3F;
      st_q.en        <= `TIP_RST_BYTE;
      st_q.een       <= `TIP_RST_EXT;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // RULE14 core pushes PC only, loads this vector
  assign hw_call     = st_q.call;
  assign call_vector = st_q.vector;
  assign call_level  = st_q.call_level;
  assign prdata      = st_q.prdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  call_gate_a: assert property (st_q.call |-> $past(core_last_cycle) && !$past(core_block_call)) // RULE6
    else $error("call outside last cycle or while blocked");
  call_return_from_interrupt_a: assert property (st_q.call |-> !$past(core_return_from_interrupt)) // RULE7
    else $error("call during return-from-interrupt");
  call_space_a: assert property (st_q.call |=> !st_q.call [*8]) // RULE20
    else $error("calls too close");
  call_phase_a: assert property (st_q.call |-> st_q.phase == `TIP_PH_C1) // RULE24
    else $error("call not aligned to machine cycle");
  no_preempt_a: assert property (st_q.call |-> !$past(st_q.in_service[1])) // RULE2
    else $error("call while high level in service");
  level_mark_a: assert property (st_q.call |-> st_q.in_service[st_q.call_level]) // RULE25
    else $error("service bit not set on call");
  return_from_interrupt_end_a: assert property (core_return_from_interrupt && st_q.in_service[1] |=> !st_q.in_service[1]) // RULE16
    else $error("return did not end high service");
  ret_keep_a: assert property (core_ret && !core_return_from_interrupt && st_q.phase != `TIP_PH_C4 |=> $stable(st_q.in_service)) // RULE17
    else $error("plain return changed service state");
  t0_clear_a: assert property (st_q.call && st_q.vector == `TIP_VEC_TIMER0 |-> !st_q.t0_flag || $past(timer0_overflow)) // RULE9
    else $error("timer 0 flag kept after vectoring");
  wdog_vec_a: assert property (st_q.call && st_q.vector == `TIP_VEC_WDOG |-> $past(st_q.polled[`TIP_SRC_WDOG])) // RULE15
    else $error("watchdog vector without request");

endmodule
`default_nettype wire

// [verilog/tip_defines.svh]
// Constants of the two-level interrupt priority controller.
// Assumes inclusion by bare name from the design file.
`ifndef TIP_DEFINES_SVH
`define TIP_DEFINES_SVH
// Machine cycle timing
`define TIP_MC_CLOCKS      3'h4
`define TIP_PH_C1          2'h0
`define TIP_PH_C3          2'h2
`define TIP_PH_C4          2'h3
`define TIP_CALL_MCYCLES   3'h4
// Register byte offsets
`define TIP_OFF_EN         8'h00
`define TIP_OFF_EEN        8'h04
`define TIP_OFF_PRI        8'h08
`define TIP_OFF_EPRI       8'h0C
`define TIP_OFF_FLAG       8'h10
`define TIP_OFF_FSET       8'h14
`define TIP_OFF_CFG        8'h18
`define TIP_OFF_STAT       8'h1C
// Field positions
`define TIP_EN_GLOBAL_BIT  7
`define TIP_SRC_TIMER0     1
`define TIP_SRC_TIMER1     3
`define TIP_SRC_WDOG       11
// Reset values
`define TIP_RST_BYTE       8'h00
`define TIP_RST_EXT        5'h00
// Vector addresses
`define TIP_VEC_EXT0       16'h0003
`define TIP_VEC_TIMER0     16'h000B
`define TIP_VEC_EXT1       16'h0013
`define TIP_VEC_TIMER1     16'h001B
`define TIP_VEC_SER0       16'h0023
`define TIP_VEC_TIMER2     16'h002B
`define TIP_VEC_SER1       16'h003B
`define TIP_VEC_EXT2       16'h0043
`define TIP_VEC_EXT3       16'h004B
`define TIP_VEC_EXT4       16'h0053
`define TIP_VEC_EXT5       16'h005B
`define TIP_VEC_WDOG       16'h0063
`endif

// [verilog/tip_pkg.sv]
// Types of the two-level interrupt priority controller.
// Assumes tip_defines.svh on the include path.
package tip_pkg;
  typedef logic [11:0] tip_src_t;

  typedef struct packed {
    logic [1:0]  phase;
    logic [5:0]  pin_s1;
    logic [5:0]  pin_s2;
    logic [5:0]  pin_s3;
    logic [5:0]  pin_lvl;
    logic [5:0]  pin_prev;
    logic [5:0]  ext_flag;
    logic        t0_flag;
    logic        t1_flag;
    tip_src_t    polled;
    logic [1:0]  in_service;
    logic [2:0]  busy;
    logic        call;
    logic        call_level;
    logic [15:0] vector;
    logic [7:0]  en;
    logic [4:0]  een;
    logic [6:0]  pri;
    logic [4:0]  epri;
    logic [1:0]  edge_mode;
    logic [3:0]  hw_clr;
    logic [31:0] prdata;
  } tip_state_s;
endpackage

// [tb/tip_core_model.sv]
// Core-side partner: last-cycle, blocking and return signalling.
// Assumes a testbench that steers it through plain control inputs.
`timescale 1ns/100ps
`default_nettype none

module tip_core_model
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic hold_off,
  input  wire logic wr_ctrl,
  input  wire logic return_from_interrupt_req,
  input  wire logic ret_req,
  output logic      core_last_cycle,
  output logic      core_block_call,
  output logic      core_return_from_interrupt,
  output logic      core_ret
);
  assign core_last_cycle = !hold_off;
  assign core_block_call = wr_ctrl;

  // returns execute one cycle after request
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      core_return_from_interrupt <= 1'b0;
      core_ret  <= 1'b0;
    end
    else
    begin
      core_return_from_interrupt <= return_from_interrupt_req;
      core_ret  <= ret_req;
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Testbench of the interrupt priority controller.
// Assumes the core partner model and APB registers as handed over.
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic        hw_call, call_level, hold_off, wr_ctrl, return_from_interrupt_req, ret_req;
  logic        lc, bc, rt, rn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] call_vector;
  logic [11:0] src;
  logic [2:0]  alt;
  int          fails, total_checks;
  logic [15:0] vec_tab [12] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
                                16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063};
  logic [11:0] keep = 12'h874;

  tip_ctrl i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_interrupt_pin_n(~{src[10:7], src[2], src[0]}), .timer0_overflow(src[1]),
    .timer1_overflow(src[3]), .serial0_receive_flag(src[4]), .serial0_transmit_flag(alt[0]),
    .timer2_overflow_flag(src[5]), .timer2_external_flag(alt[1]), .serial1_receive_flag(alt[2]),
    .serial1_transmit_flag(src[6]), .watchdog_interrupt_flag(src[11]), .core_last_cycle(lc),
    .core_block_call(bc), .core_return_from_interrupt(rt), .core_ret(rn), .hw_call(hw_call),
    .call_vector(call_vector), .call_level(call_level));

  tip_core_model i_core (.clk(clk), .srst(srst), .hold_off(hold_off), .wr_ctrl(wr_ctrl),
    .return_from_interrupt_req(return_from_interrupt_req), .ret_req(ret_req), .core_last_cycle(lc), .core_block_call(bc),
    .core_return_from_interrupt(rt), .core_ret(rn));

  // Free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No own limit; only the hang guard ends a stuck wait
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never re-drives psel in this time step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, msg);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic st(input logic [1:0] exp, input string msg);
    logic [31:0] q;
    logic        e;
    apb(1'b0, 8'h1C, 32'h0, q, e);
    chk(q[1:0], exp, msg);
  endtask

  // Bounded wait for the call pulse, then its vector and level
  task automatic wait_call(input logic [15:0] vec, input logic lvl, input string msg);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hw_call !== 1'b1 && n < 80);
    chk(hw_call, 1'b1, msg);
    chk(call_vector, vec, msg);
    chk(call_level, lvl, msg);
  endtask

  // Ten machine cycles with no call at all
  task automatic no_call(input string msg);
    logic seen;
    seen = 1'b0;
    repeat (40)
    begin
      @(posedge clk);
      if (hw_call !== 1'b0)
        seen = 1'b1;
    end
    chk(seen, 1'b0, msg);
  endtask

  task automatic ret_pulse(input logic full);
    if (full)
      return_from_interrupt_req <= 1'b1;
    else
      ret_req <= 1'b1;
    @(posedge clk);
    return_from_interrupt_req <= 1'b0;
    ret_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rd(8'h00, 32'h0, "enable reset");
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk(e, 1'b1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    wr(8'h00, 32'hFF);
    wr(8'h04, 32'h1F);
    // Ext0 edge mode, ext1 level mode, all hardware clears on
    wr(8'h18, 32'h3D);
    rd(8'h18, 32'h3D, "cfg readback");
  endtask

  // Every source alone: vector, then which flags vectoring clears
  task automatic t_vectors;
    for (int i = 0; i < 12; i++)
    begin
      src[i] <= 1'b1;
      @(posedge clk);
      src[1] <= 1'b0;
      src[3] <= 1'b0;
      wait_call(vec_tab[i], 1'b0, "vector");
      rd(8'h10, keep[i] ? (32'h1 << i) : 32'h0, "flag after call");
      src <= 12'h000;
      ret_pulse(1'b1);
      repeat (8) @(posedge clk);
    end
  endtask

  task automatic t_levels;
    alt[0] <= 1'b1;
    src[11] <= 1'b1;
    wait_call(16'h0023, 1'b0, "fixed order");
    no_call("equal level in service");
    wr(8'h0C, 32'h10);
    wait_call(16'h0063, 1'b1, "high preempts low");
    st(2'b11, "both in service");
    ret_pulse(1'b0);
    st(2'b11, "plain return");
    src <= 12'h000;
    alt <= 3'h0;
    wr(8'h0C, 32'h0);
    ret_pulse(1'b1);
    st(2'b01, "return ends high");
    ret_pulse(1'b1);
    st(2'b00, "return ends low");
  endtask

  task automatic t_gating;
    wr(8'h00, 32'h7F);
    alt[2:1] <= 2'b11;
    no_call("global off");
    hold_off <= 1'b1;
    wr(8'h00, 32'hFF);
    no_call("not last cycle");
    hold_off <= 1'b0;
    wr_ctrl <= 1'b1;
    no_call("blocked instruction");
    wr_ctrl <= 1'b0;
    wait_call(16'h002B, 1'b0, "timer2 external flag");
    alt[1] <= 1'b0;
    ret_pulse(1'b1);
    wait_call(16'h003B, 1'b0, "serial1 receive flag");
    alt <= 3'h0;
    ret_pulse(1'b1);
  endtask

  // Reset in mid-run with a service active; nothing of it may survive
  task automatic t_reset;
    src[11] <= 1'b1;
    wait_call(16'h0063, 1'b0, "call before reset");
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    src <= 12'h000;
    @(posedge clk);
    st(2'b00, "reset clears service");
    rd(8'h00, 32'h0, "reset clears enables");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard, well beyond the several hundred cycles of the tests
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {hold_off, wr_ctrl, return_from_interrupt_req, ret_req} = 4'h0;
    src = 12'h000;
    alt = 3'h0;
    srst = 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_vectors();
    t_levels();
    t_gating();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
